// ---- verilog/sfm_defines.svh ----
/*
 * Register offsets, field positions, reset values and timing counts for the
 * skip-speed and fire-mode controller.
 * Assumes a 40 MHz pclk and APB with 32-bit data.
 */
`ifndef SFM_DEFINES_SVH
`define SFM_DEFINES_SVH

`define SFM_OFF_SKIP_ONE      12'h000
`define SFM_OFF_SKIP_TWO      12'h004
`define SFM_OFF_SKIP_HALF     12'h008
`define SFM_OFF_MAX_SPEED     12'h00C
`define SFM_OFF_FIRE_CFG      12'h010
`define SFM_OFF_PID_TARGET    12'h014
`define SFM_OFF_CONTROL       12'h018
`define SFM_OFF_SPEED_REQ     12'h01C
`define SFM_OFF_SPEED_OUT     12'h020
`define SFM_OFF_STATUS        12'h024
`define SFM_OFF_IRQ_STATUS    12'h028
`define SFM_OFF_IRQ_MASK      12'h02C

`define SFM_SPEED_MAX         16'h4650
`define SFM_RST_SKIP_ONE      16'h0258
`define SFM_RST_SKIP_TWO      16'h0384
`define SFM_RST_SKIP_HALF     16'h0000
`define SFM_RST_MAX_SPEED     16'h0708
`define SFM_RST_FIRE_CFG      3'h0
`define SFM_FIRE_CFG_MAX      3'h4
`define SFM_PID_TARGET_MAX    16'h03E8
`define SFM_PID_TARGET_MIN    16'hFC18
`define SFM_RST_PID_TARGET    16'h03E8

`define SFM_CTL_ENABLE        0
`define SFM_CTL_GEN_AUTORESET 1
`define SFM_CTL_FIRE_AUTORST  2
`define SFM_CTL_ESCAPE        3
`define SFM_CTL_STOP          4
`define SFM_CTL_CLR_RECORD    5

`define SFM_IRQ_FIRE_ENTER    0
`define SFM_IRQ_FIRE_LEAVE    1
`define SFM_IRQ_CRIT_FAULT    2
`define SFM_IRQ_WIDTH         3

`define SFM_AUTORESET_TIME_MS 1000
`define SFM_CLK_KHZ           40000
`define SFM_AUTORESET_CYCLES  (`SFM_AUTORESET_TIME_MS * `SFM_CLK_KHZ)
`endif

// ---- verilog/sfm_pkg.sv ----
/*
 * Types shared by the skip-speed and fire-mode controller.
 * Assumes sfm_defines.svh gives the numeric constants.
 */
package sfm_pkg;
    typedef enum logic [1:0] {
        SFM_STATE_NORMAL,
        SFM_STATE_FIRE,
        SFM_STATE_FIRE_ESCAPED
    } sfm_state_type;

    typedef struct packed {
        logic fire_mode_alarm;
        logic alarm_on_main;
        logic alarm_on_secondary;
        logic fire_mode_output;
        logic pulses_enable;
        logic pid_override;
        logic run_allowed;
    } sfm_drive_out_type;

    typedef struct packed {
        logic dc_link_overvoltage_fault;
        logic overcurrent_short_fault;
        logic other_fault;
    } sfm_fault_type;
endpackage

// ---- verilog/sfm_ctrl.sv ----
/*
 * Skip-speed reference shaping and fire-mode manager with an APB slave.
 * Assumes all pins are synchronous to pclk except fire_input_n, and that a
 * ramp generator downstream turns the shaped reference into a ramped speed.
 */
// Decided for this implementation: the APB interface to the registers and the address map.
`include "sfm_defines.svh"

module sfm_ctrl
    import sfm_pkg::*;
#(
    parameter int unsigned AUTORESET_CYCLES = `SFM_AUTORESET_CYCLES
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              fire_input_n,
    input  wire sfm_fault_type     fault_in,
    output sfm_fault_type          fault_out,
    output logic      [15:0]       speed_reference,
    output logic      [15:0]       pid_setpoint,
    output sfm_drive_out_type      drive_out,
    output logic      [1:0]        drive_state_indicator,
    output logic                   fire_record,
    output logic                   irq
);
    logic [15:0]         skip_one_reg;
    logic [15:0]         skip_two_reg;
    logic [15:0]         half_reg;
    logic [15:0]         max_speed_reg;
    logic [2:0]          fire_cfg_reg;
    logic [15:0]         pid_target_reg;
    logic [4:0]          control_reg;
    logic [15:0]         speed_req_reg;
    logic [15:0]         speed_out_reg;
    logic [15:0]         pid_out_reg;
    logic [`SFM_IRQ_WIDTH-1:0] irq_status_reg;
    logic [`SFM_IRQ_WIDTH-1:0] irq_mask_reg;
    logic                fire_sync1_reg;
    logic                fire_sync2_reg;
    logic                record_reg;
    sfm_state_type       state_reg;
    sfm_state_type       state_next;
    sfm_drive_out_type   drive_out_reg;
    sfm_fault_type       fault_latch_reg;
    logic [31:0]         rst_count_reg;
    logic [31:0]         prdata_reg;

    wire        wr_en      = psel & penable & pwrite;
    wire        rd_setup   = psel & ~penable & ~pwrite;
    wire [15:0] wdata16    = pwdata[15:0];
    wire        addr_ok    = (paddr <= `SFM_OFF_IRQ_MASK) && (paddr[1:0] == 2'b00);
    wire        wr_cfg     = wr_en & (paddr == `SFM_OFF_FIRE_CFG);
    wire        wr_ctl     = wr_en & (paddr == `SFM_OFF_CONTROL);
    wire        wr_irq_clr = wr_en & (paddr == `SFM_OFF_IRQ_STATUS);
    wire        fire_req   = ~fire_sync2_reg & (fire_cfg_reg != 3'h0);
    wire        in_fire    = (state_reg != SFM_STATE_NORMAL);

    // Skip windows are computed in 17 bits so an edge past full scale cannot wrap.
    wire [16:0] lo_one = {1'b0, skip_one_reg} - {1'b0, half_reg};
    wire [16:0] hi_one = {1'b0, skip_one_reg} + {1'b0, half_reg};
    wire [16:0] lo_two = {1'b0, skip_two_reg} - {1'b0, half_reg};
    wire [16:0] hi_two = {1'b0, skip_two_reg} + {1'b0, half_reg};
    wire [16:0] req17  = {1'b0, speed_req_reg};
    wire        lo_one_neg = lo_one[16];
    wire        lo_two_neg = lo_two[16];
    wire [15:0] lo_one_c = lo_one_neg ? 16'h0000 : lo_one[15:0];
    wire [15:0] lo_two_c = lo_two_neg ? 16'h0000 : lo_two[15:0];
    wire [15:0] hi_one_c = hi_one[16] ? 16'hFFFF : hi_one[15:0];
    wire [15:0] hi_two_c = hi_two[16] ? 16'hFFFF : hi_two[15:0];
    // A zero half-width gives an empty window, so nothing is skipped.
    wire        in_one = (half_reg != 16'h0000) && (req17 > (lo_one_neg ? 17'h0_0000 : lo_one))
                         && (req17 < hi_one);
    wire        in_two = (half_reg != 16'h0000) && (req17 > (lo_two_neg ? 17'h0_0000 : lo_two))
                         && (req17 < hi_two);
    wire        near_lo_one = (speed_req_reg - lo_one_c) <= (hi_one_c - speed_req_reg);
    wire        near_lo_two = (speed_req_reg - lo_two_c) <= (hi_two_c - speed_req_reg);
    wire [15:0] shaped_ref = in_one ? (near_lo_one ? lo_one_c : hi_one_c) :
                             in_two ? (near_lo_two ? lo_two_c : hi_two_c) :
                             speed_req_reg;
    wire        force_max  = in_fire & (fire_cfg_reg == 3'h2);
    wire        force_pid  = in_fire & (fire_cfg_reg == 3'h3);
    wire        coast      = in_fire & (fire_cfg_reg == 3'h4);
    wire [15:0] ref_next   = force_max ? max_speed_reg : shaped_ref;
    wire        run_next   = in_fire | (control_reg[`SFM_CTL_ENABLE]
                             & ~control_reg[`SFM_CTL_STOP]);
    wire        auto_rst_on = in_fire ? control_reg[`SFM_CTL_FIRE_AUTORST]
                              : control_reg[`SFM_CTL_GEN_AUTORESET];
    wire        crit_now   = fault_in.dc_link_overvoltage_fault | fault_in.overcurrent_short_fault;
    wire        crit_held  = fault_latch_reg.dc_link_overvoltage_fault
                             | fault_latch_reg.overcurrent_short_fault;
    wire        rst_done   = crit_held & auto_rst_on & (rst_count_reg == AUTORESET_CYCLES - 1);
    wire        enter_evt  = (state_reg == SFM_STATE_NORMAL) & (state_next != SFM_STATE_NORMAL);
    wire        leave_evt  = in_fire & (state_next == SFM_STATE_NORMAL);
    wire        crit_evt   = crit_now & ~crit_held;
    wire [`SFM_IRQ_WIDTH-1:0] irq_set = {crit_evt, leave_evt, enter_evt};
    wire [15:0] status_word = {11'h000, record_reg, in_fire, state_reg, fire_sync2_reg};
    wire [31:0] rd_mux =
        (paddr == `SFM_OFF_SKIP_ONE)   ? {16'h0000, skip_one_reg}     :
        (paddr == `SFM_OFF_SKIP_TWO)   ? {16'h0000, skip_two_reg}     :
        (paddr == `SFM_OFF_SKIP_HALF)  ? {16'h0000, half_reg}         :
        (paddr == `SFM_OFF_MAX_SPEED)  ? {16'h0000, max_speed_reg}    :
        (paddr == `SFM_OFF_FIRE_CFG)   ? {29'h0000_0000, fire_cfg_reg} :
        (paddr == `SFM_OFF_PID_TARGET) ? {16'h0000, pid_target_reg}   :
        (paddr == `SFM_OFF_CONTROL)    ? {27'h000_0000, control_reg}  :
        (paddr == `SFM_OFF_SPEED_REQ)  ? {16'h0000, speed_req_reg}    :
        (paddr == `SFM_OFF_SPEED_OUT)  ? {16'h0000, speed_out_reg}    :
        (paddr == `SFM_OFF_STATUS)     ? {16'h0000, status_word}      :
        (paddr == `SFM_OFF_IRQ_STATUS) ? {29'h0000_0000, irq_status_reg} :
        (paddr == `SFM_OFF_IRQ_MASK)   ? {29'h0000_0000, irq_mask_reg} :
        32'h0000_0000;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SFM_STATE_NORMAL: begin
                if (fire_req) begin
                    state_next = SFM_STATE_FIRE;
                end
            end
            SFM_STATE_FIRE: begin
                if (!fire_req) begin
                    state_next = SFM_STATE_NORMAL;
                end else if (wr_ctl && pwdata[`SFM_CTL_ESCAPE]) begin
                    state_next = SFM_STATE_FIRE_ESCAPED;
                end
            end
            SFM_STATE_FIRE_ESCAPED: begin
                if (!fire_req) begin
                    state_next = SFM_STATE_NORMAL;
                end
            end
            default: state_next = SFM_STATE_NORMAL;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = prdata_reg;
    assign irq     = |(irq_status_reg & irq_mask_reg);
    assign speed_reference       = speed_out_reg;
    assign pid_setpoint          = pid_out_reg;
    assign drive_out             = drive_out_reg;
    assign fault_out             = fault_latch_reg;
    assign fire_record           = record_reg;
    assign drive_state_indicator = {1'b0, in_fire};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fire_sync1_reg <= 1'b1;
            fire_sync2_reg <= 1'b1;
        end else begin
            fire_sync1_reg <= fire_input_n;
            fire_sync2_reg <= fire_sync1_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_one_reg   <= `SFM_RST_SKIP_ONE;
            skip_two_reg   <= `SFM_RST_SKIP_TWO;
            half_reg       <= `SFM_RST_SKIP_HALF;
            max_speed_reg  <= `SFM_RST_MAX_SPEED;
            pid_target_reg <= `SFM_RST_PID_TARGET;
            speed_req_reg  <= 16'h0000;
            irq_mask_reg   <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                `SFM_OFF_SKIP_ONE:   skip_one_reg <= (wdata16 > `SFM_SPEED_MAX) ? `SFM_SPEED_MAX : wdata16;
                `SFM_OFF_SKIP_TWO:   skip_two_reg <= (wdata16 > `SFM_SPEED_MAX) ? `SFM_SPEED_MAX : wdata16;
                `SFM_OFF_SKIP_HALF:  half_reg <= (wdata16 > `SFM_SPEED_MAX) ? `SFM_SPEED_MAX : wdata16;
                `SFM_OFF_MAX_SPEED:  max_speed_reg <= (wdata16 > `SFM_SPEED_MAX) ? `SFM_SPEED_MAX : wdata16;
                `SFM_OFF_PID_TARGET: pid_target_reg <=
                    ($signed(wdata16) > $signed(`SFM_PID_TARGET_MAX)) ? `SFM_PID_TARGET_MAX :
                    ($signed(wdata16) < $signed(`SFM_PID_TARGET_MIN)) ? `SFM_PID_TARGET_MIN :
                    wdata16;
                `SFM_OFF_SPEED_REQ:  speed_req_reg <= wdata16;
                `SFM_OFF_IRQ_MASK:   irq_mask_reg <= pwdata[`SFM_IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fire_cfg_reg <= `SFM_RST_FIRE_CFG;
            control_reg  <= 5'h00;
        end else begin
            if (wr_cfg && pwdata[2:0] <= `SFM_FIRE_CFG_MAX) begin
                fire_cfg_reg <= pwdata[2:0];
            end
            if (wr_ctl) begin
                control_reg <= {pwdata[`SFM_CTL_STOP], 1'b0, pwdata[2:0]};
            end
        end
    end

    // Escape is a one-shot write, so bit 3 of control is never stored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg      <= SFM_STATE_NORMAL;
            record_reg     <= 1'b0;
            irq_status_reg <= '0;
            prdata_reg     <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            // Clearing the record only works outside fire mode so it cannot be hidden.
            record_reg <= (record_reg & ~(wr_ctl & pwdata[`SFM_CTL_CLR_RECORD] & ~in_fire))
                          | enter_evt;
            irq_status_reg <= (irq_status_reg & ~(wr_irq_clr ? pwdata[`SFM_IRQ_WIDTH-1:0] : '0))
                              | irq_set;
            if (rd_setup) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_out_reg <= 16'h0000;
            pid_out_reg   <= 16'h0000;
            drive_out_reg <= '0;
        end else begin
            speed_out_reg <= ref_next;
            pid_out_reg   <= force_pid ? pid_target_reg : 16'h0000;
            drive_out_reg.fire_mode_alarm    <= in_fire;
            drive_out_reg.alarm_on_main      <= (state_reg == SFM_STATE_FIRE);
            drive_out_reg.alarm_on_secondary <= (state_reg == SFM_STATE_FIRE_ESCAPED);
            drive_out_reg.fire_mode_output   <= in_fire;
            drive_out_reg.pulses_enable      <= run_next & ~coast & ~crit_held;
            drive_out_reg.pid_override       <= force_pid;
            drive_out_reg.run_allowed        <= run_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_latch_reg <= '0;
            rst_count_reg   <= 32'h0000_0000;
        end else begin
            fault_latch_reg.dc_link_overvoltage_fault <= fault_in.dc_link_overvoltage_fault
                | (fault_latch_reg.dc_link_overvoltage_fault & ~rst_done);
            fault_latch_reg.overcurrent_short_fault <= fault_in.overcurrent_short_fault
                | (fault_latch_reg.overcurrent_short_fault & ~rst_done);
            fault_latch_reg.other_fault <= fault_in.other_fault & ~in_fire;
            if (!crit_held || !auto_rst_on || rst_done) begin
                rst_count_reg <= 32'h0000_0000;
            end else begin
                rst_count_reg <= rst_count_reg + 32'h0000_0001;
            end
        end
    end
endmodule

// ---- verification/sfm_ctrl_checker.sv ----
/*
 * Concurrent checks on the ports of the skip-speed and fire-mode controller.
 * Assumes one pclk domain with presetn as its asynchronous active-low reset.
 */
module sfm_ctrl_checker
    import sfm_pkg::*;
#(
    parameter int unsigned AUTORESET_CYCLES = 20
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pslverr,
    input wire logic              fire_input_n,
    input wire sfm_fault_type     fault_in,
    input wire sfm_fault_type     fault_out,
    input wire logic [15:0]       pid_setpoint,
    input wire sfm_drive_out_type drive_out,
    input wire logic [1:0]        drive_state_indicator,
    input wire logic              fire_record
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    fire_entry_a: assert property ($rose(drive_state_indicator != 2'b00) |->
        $past(fire_input_n, 3) == 1'b0) else $error("fire entered without a request");
    fire_leave_a: assert property ($fell(drive_state_indicator != 2'b00) |->
        $past(fire_input_n, 3) == 1'b1) else $error("fire left while requested");
    alarm_raise_a: assert property ($rose(drive_state_indicator != 2'b00) |=>
        drive_out.fire_mode_alarm && drive_out.alarm_on_main) else $error("alarm not raised");
    alarm_move_a: assert property (drive_out.alarm_on_secondary |->
        drive_out.fire_mode_alarm && !drive_out.alarm_on_main) else $error("alarm shown twice");
    fire_output_a: assert property (drive_out.fire_mode_output ==
        ($past(drive_state_indicator) != 2'b00)) else $error("fire output wrong");
    stop_ignored_a: assert property ((drive_state_indicator != 2'b00)[*2] |->
        drive_out.run_allowed) else $error("stopped in fire mode");
    fault_mask_a: assert property ((drive_state_indicator != 2'b00)[*2] |->
        !fault_out.other_fault) else $error("minor fault kept in fire mode");
    fault_pass_a: assert property ((drive_state_indicator == 2'b00)[*2] |->
        fault_out.other_fault == $past(fault_in.other_fault)) else $error("minor fault lost");
    record_set_a: assert property ($rose(fire_record) |->
        drive_state_indicator != 2'b00) else $error("record set outside fire");
    pid_fire_a: assert property (pid_setpoint != 16'h0000 |->
        $past(drive_state_indicator) != 2'b00) else $error("setpoint forced outside fire");
    apb_err_a: assert property (pslverr |-> psel && penable) else $error("stray slave error");

    cover property ($rose(drive_state_indicator != 2'b00));
    cover property (drive_out.alarm_on_secondary);
    cover property (fault_out.dc_link_overvoltage_fault);
    cover property (pslverr);
endmodule

bind sfm_ctrl sfm_ctrl_checker #(.AUTORESET_CYCLES(AUTORESET_CYCLES)) u_sfm_ctrl_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
    .fire_input_n(fire_input_n), .fault_in(fault_in), .fault_out(fault_out),
    .pid_setpoint(pid_setpoint), .drive_out(drive_out),
    .drive_state_indicator(drive_state_indicator), .fire_record(fire_record));

// ---- verification/sfm_motor_alarm.sv ----
/*
 * Far side model: the fire-alarm contact and the fault sensing of the motor stage.
 * Assumes the bench opens the contact and raises faults in step with pclk.
 */
module sfm_motor_alarm
    import sfm_pkg::*;
(
    input wire logic          alarm_open,
    input wire sfm_fault_type fault_set,
    output logic              fire_input_n,
    output sfm_fault_type     fault_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // An opened contact leaves the input at 0 V, which is the fire request.
    assign fire_input_n = ~alarm_open;
    assign fault_in = fault_set;
endmodule

// ---- verification/sfm_ctrl_tb.sv ----
/*
 * Self-checking bench for the skip-speed and fire-mode controller over APB.
 * Assumes the auto-reset count is shortened to 20 cycles for simulation.
 */
`include "sfm_defines.svh"
module sfm_ctrl_tb;
    import sfm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic              fire_req, fire_input_n, fire_record, irq;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [15:0]       speed_reference, pid_setpoint;
    logic [1:0]        drive_state_indicator;
    sfm_fault_type     fault_set, fault_in, fault_out;
    sfm_drive_out_type drive_out;
    int                miscompares, n_compared;
    logic [15:0] req_tab [7] = '{16'h01F4, 16'h0230, 16'h0258, 16'h0280, 16'h028A, 16'h0370, 16'h03AC};
    logic [15:0] exp_tab [7] = '{16'h01F4, 16'h0226, 16'h0226, 16'h028A, 16'h028A, 16'h0352, 16'h03B6};
    logic [31:0] rst_tab [6] = '{32'h0000_0258, 32'h0000_0384, 32'h0, 32'h0000_0708, 32'h0, 32'h0000_03E8};

    sfm_ctrl #(.AUTORESET_CYCLES(20)) u_sfm_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fire_input_n(fire_input_n), .fault_in(fault_in),
        .fault_out(fault_out), .speed_reference(speed_reference), .pid_setpoint(pid_setpoint),
        .drive_out(drive_out), .drive_state_indicator(drive_state_indicator),
        .fire_record(fire_record), .irq(irq));
    sfm_motor_alarm u_sfm_motor_alarm (.alarm_open(fire_req), .fault_set(fault_set),
        .fire_input_n(fire_input_n), .fault_in(fault_in));

    task automatic stop_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Setup, access until pready, then one idle edge so back-to-back calls never clash.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        cyc(20000);
        miscompares++;
        stop_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, fire_req} = 5'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fault_set = 3'b000;
        cyc(3);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rdc(12'(4 * i), rst_tab[i]);
        rdc(12'h030, 32'h0);
        check(err, 1'b1);
        wr(`SFM_OFF_SKIP_ONE, 32'h0000_FFFF);
        rdc(`SFM_OFF_SKIP_ONE, 32'h0000_4650);
        wr(`SFM_OFF_SKIP_ONE, 32'h0000_0258);
        wr(`SFM_OFF_SKIP_HALF, 32'h0000_0032);
        for (int i = 0; i < 7; i++) begin
            wr(`SFM_OFF_SPEED_REQ, {16'h0, req_tab[i]});
            // The shaped reference is launched at the edge the write task ends on.
            cyc(1);
            check(speed_reference, exp_tab[i]);
            rdc(`SFM_OFF_SPEED_OUT, {16'h0, exp_tab[i]});
        end
        wr(`SFM_OFF_SKIP_HALF, 32'h0);
        wr(`SFM_OFF_SPEED_REQ, 32'h0000_0258);
        cyc(1);
        check(speed_reference, 16'h0258);
        wr(`SFM_OFF_SPEED_REQ, 32'h0000_01F4);
        wr(`SFM_OFF_CONTROL, 32'h0000_0015);
        wr(`SFM_OFF_IRQ_MASK, 32'h0000_0001);
        check(drive_out.run_allowed, 1'b0);
        fault_set <= 3'b001;
        cyc(3);
        check(fault_out, 3'b001);
        fault_set <= 3'b000;
        wr(`SFM_OFF_FIRE_CFG, 32'h0000_0005);
        rdc(`SFM_OFF_FIRE_CFG, 32'h0);
        fire_req <= 1'b1;
        cyc(8);
        check({drive_state_indicator, drive_out.fire_mode_output}, 3'b000);
        fire_req <= 1'b0;
        cyc(4);
        for (int c = 1; c <= 4; c++) begin
            wr(`SFM_OFF_FIRE_CFG, 32'(c));
            fire_req <= 1'b1;
            cyc(6);
            check(drive_state_indicator, 2'b01);
            check(drive_out.fire_mode_output, 1'b1);
            check(drive_out.run_allowed, 1'b1);
            check(speed_reference, c == 2 ? 16'h0708 : 16'h01F4);
            check(pid_setpoint, c == 3 ? 16'h03E8 : 16'h0000);
            check(drive_out.pulses_enable, c != 4);
            if (c == 1) begin
                check(irq, 1'b1);
                wr(`SFM_OFF_IRQ_STATUS, 32'h0000_0001);
                check(irq, 1'b0);
                fault_set <= 3'b101;
                cyc(3);
                check(fault_out, 3'b100);
                fault_set <= 3'b000;
                cyc(40);
                check(fault_out, 3'b000);
                wr(`SFM_OFF_CONTROL, 32'h0000_001D);
                cyc(2);
                check({drive_out.alarm_on_main, drive_out.alarm_on_secondary}, 2'b01);
                check(drive_state_indicator, 2'b01);
            end
            fire_req <= 1'b0;
            cyc(6);
            check({drive_state_indicator, drive_out.run_allowed}, 3'b000);
            check(fire_record, 1'b1);
        end
        rdc(`SFM_OFF_IRQ_STATUS, 32'h0000_0007);
        check(irq, 1'b1);
        wr(`SFM_OFF_IRQ_MASK, 32'h0);
        check(irq, 1'b0);
        stop_test();
    end
endmodule
